/* verilog/slow_timer_pkg.sv */
/*
  Constants for the slow clock system timer: register byte offsets, field
  positions, reset values, bus answers and timing counts.
  Assumes one clock that stands for the slow clock, one count per edge.
*/
// Notes on behaviour
// - Restart bit one reloads watchdog counter
// - Interval value sets period; zero means 65536
// - Watchdog value sets load; zero means maximum
// - Reset enable gates internal reset on overflow
// - Output enable gives eight-cycle low overflow pulse
// - Prescaler sets increment interval; zero means 65536
// - Status bit0 flags interval expiry, read clears
// - Status bit1 flags watchdog overflow, read clears
// - Status bit2 flags elapsed increment, read clears
// - Status bit3 flags alarm match, read clears
// - Enable register ones set mask bits
// - Disable register ones clear mask bits
// - Mask register reads enabled flags
// - Alarm value compared; zero means longest delay
// - Current register returns 20-bit elapsed count
// - Interval counter reloads itself at zero
// - Interval mode write reloads and restarts counter
// - Elapsed mode write restarts prescaler, clears count
// - Restart resets prescaler; mode write does not
`default_nettype none

package slow_timer_pkg;

  // ****************************************
  // Bus
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIODIC_INTERVAL_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_WATCHDOG_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ELAPSED_TIME_MODE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TIMER_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_DISABLE = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_INTERRUPT_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_ELAPSED_TIME_ALARM = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_ELAPSED_TIME_CURRENT = 8'h24;

  // ****************************************
  // Fields
  // ****************************************
  localparam int WATCHDOG_RESTART_BIT = 0;
  localparam int COUNT_W = 16;
  localparam int OVERFLOW_RESET_ENABLE_BIT = 16;
  localparam int OVERFLOW_OUTPUT_ENABLE_BIT = 17;
  localparam int ELAPSED_W = 20;
  localparam int N_FLAGS = 4;
  localparam int FLAG_INTERVAL = 0;
  localparam int FLAG_WATCHDOG = 1;
  localparam int FLAG_INCREMENT = 2;
  localparam int FLAG_ALARM = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] PERIODIC_INTERVAL_MODE_RST = 32'h00000000;
  localparam logic [31:0] WATCHDOG_MODE_RST = 32'h00020000;
  localparam logic [31:0] ELAPSED_TIME_MODE_RST = 32'h00008000;
  localparam logic [31:0] ELAPSED_TIME_ALARM_RST = 32'h00000000;

  // ****************************************
  // Timing: watchdog prescaler width in bits, pulse length in slow clock cycles
  // ****************************************
  localparam int WATCHDOG_PRESCALE_W = 7;
  localparam int OVERFLOW_PULSE_CYCLES = 8;

endpackage : slow_timer_pkg

`default_nettype wire

/* verilog/reload_counter.sv */
/*
  Down counter that reloads itself: a load value of n gives a wrap every n
  enabled cycles, and zero gives the full 2**W.
  Assumes restart and enable come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module reload_counter #(
  parameter int W = 16,
  parameter logic [W-1:0] RESET_COUNT = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic enable,
  input wire logic [W-1:0] load_value,
  output logic [W-1:0] count,
  output logic wrap
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic [W-1:0] reload;

  // Load minus one wraps zero to all ones, the longest period
  assign reload = W'(load_value - 1'b1);
  assign wrap = enable && (count_reg == '0);
  assign count_next = restart ? reload :
                      wrap ? reload :
                      enable ? W'(count_reg - 1'b1) : count_reg;
  assign count = count_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= RESET_COUNT;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : reload_counter

`default_nettype wire

/* verilog/slow_clock_system_timer.sv */
/*
  Slow clock system timer: interval counter, watchdog with prescaler and
  overflow outputs, elapsed-time counter with alarm, AXI4-Lite registers.
  Assumes clk is the slow clock and the master keeps AXI4-Lite rules.
*/
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module slow_clock_system_timer
  import slow_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_irq,
  output logic watchdog_reset,
  output logic overflow_output_n
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] byte_merge(input logic [31:0] old_word, input logic [31:0] new_word,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return res;
  endfunction : byte_merge

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= OFF_ELAPSED_TIME_CURRENT);
  endfunction : is_mapped

  // ****************************************
  // State
  // ****************************************
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic [COUNT_W-1:0] interval_load_value_reg;
  logic [COUNT_W-1:0] watchdog_load_value_reg;
  logic overflow_reset_enable_reg, overflow_output_enable_reg;
  logic [COUNT_W-1:0] elapsed_prescaler_reg;
  logic [ELAPSED_W-1:0] alarm_compare_value_reg;
  logic [ELAPSED_W-1:0] elapsed_count_value_reg;
  logic [N_FLAGS-1:0] timer_status_reg, timer_status_next;
  logic [N_FLAGS-1:0] interrupt_mask_reg, interrupt_mask_next;
  logic [3:0] pulse_count_reg, pulse_count_next;
  logic irq_reg, watchdog_reset_reg, overflow_output_n_reg;

  // ****************************************
  // Write path decode
  // ****************************************
  logic aw_take, w_take, do_write, b_done, ar_take, r_done;
  logic [31:0] wr_cmd;
  logic wr_ctrl, wr_pimr, wr_wdmr, wr_rtmr, wr_ier, wr_idr, wr_rtar, wr_mapped;
  logic [31:0] pimr_word, wdmr_word, rtmr_word, rtar_word;

  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  // Both halves held and no answer pending
  assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
  assign b_done = bvalid_reg && s_axi_bready;
  assign ar_take = s_axi_arvalid && arready_reg;
  assign r_done = rvalid_reg && s_axi_rready;
  // Command words: lanes not strobed count as zero
  assign wr_cmd = byte_merge(32'h00000000, wr_data_reg, wr_strb_reg);
  assign wr_mapped = is_mapped(wr_addr_reg);
  assign wr_ctrl = do_write && (wr_addr_reg == OFF_TIMER_CONTROL);
  assign wr_pimr = do_write && (wr_addr_reg == OFF_PERIODIC_INTERVAL_MODE);
  assign wr_wdmr = do_write && (wr_addr_reg == OFF_WATCHDOG_MODE);
  assign wr_rtmr = do_write && (wr_addr_reg == OFF_ELAPSED_TIME_MODE);
  assign wr_ier = do_write && (wr_addr_reg == OFF_INTERRUPT_ENABLE);
  assign wr_idr = do_write && (wr_addr_reg == OFF_INTERRUPT_DISABLE);
  assign wr_rtar = do_write && (wr_addr_reg == OFF_ELAPSED_TIME_ALARM);

  assign pimr_word = {16'h0000, interval_load_value_reg};
  assign wdmr_word = {14'h0000, overflow_output_enable_reg, overflow_reset_enable_reg, watchdog_load_value_reg};
  assign rtmr_word = {16'h0000, elapsed_prescaler_reg};
  assign rtar_word = {12'h000, alarm_compare_value_reg};

  logic [31:0] pimr_new, wdmr_new, rtmr_new, rtar_new;
  assign pimr_new = byte_merge(pimr_word, wr_data_reg, wr_strb_reg);
  assign wdmr_new = byte_merge(wdmr_word, wr_data_reg, wr_strb_reg);
  assign rtmr_new = byte_merge(rtmr_word, wr_data_reg, wr_strb_reg);
  assign rtar_new = byte_merge(rtar_word, wr_data_reg, wr_strb_reg);

  // ****************************************
  // Read path decode
  // ****************************************
  logic rd_status;
  logic [31:0] rd_word;

  assign rd_status = ar_take && (s_axi_araddr == OFF_TIMER_STATUS);
  assign rd_word = (s_axi_araddr == OFF_PERIODIC_INTERVAL_MODE) ? pimr_word :
                   (s_axi_araddr == OFF_WATCHDOG_MODE) ? wdmr_word :
                   (s_axi_araddr == OFF_ELAPSED_TIME_MODE) ? rtmr_word :
                   (s_axi_araddr == OFF_TIMER_STATUS) ? {28'h0000000, timer_status_reg} :
                   (s_axi_araddr == OFF_INTERRUPT_MASK) ? {28'h0000000, interrupt_mask_reg} :
                   (s_axi_araddr == OFF_ELAPSED_TIME_ALARM) ? rtar_word :
                   (s_axi_araddr == OFF_ELAPSED_TIME_CURRENT) ? {12'h000, elapsed_count_value_reg} :
                   32'h00000000;

  // ****************************************
  // Bus slave
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 32'h00000000;
      wr_strb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        wr_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        awready_reg <= 1'b1;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        wr_data_reg <= s_axi_wdata;
        wr_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        wready_reg <= 1'b1;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Mode registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_load_value_reg <= PERIODIC_INTERVAL_MODE_RST[COUNT_W-1:0];
      watchdog_load_value_reg <= WATCHDOG_MODE_RST[COUNT_W-1:0];
      overflow_reset_enable_reg <= WATCHDOG_MODE_RST[OVERFLOW_RESET_ENABLE_BIT];
      overflow_output_enable_reg <= WATCHDOG_MODE_RST[OVERFLOW_OUTPUT_ENABLE_BIT];
      elapsed_prescaler_reg <= ELAPSED_TIME_MODE_RST[COUNT_W-1:0];
      alarm_compare_value_reg <= ELAPSED_TIME_ALARM_RST[ELAPSED_W-1:0];
    end else begin
      if (wr_pimr) begin
        interval_load_value_reg <= pimr_new[COUNT_W-1:0];
      end
      if (wr_wdmr) begin
        watchdog_load_value_reg <= wdmr_new[COUNT_W-1:0];
        overflow_reset_enable_reg <= wdmr_new[OVERFLOW_RESET_ENABLE_BIT];
        overflow_output_enable_reg <= wdmr_new[OVERFLOW_OUTPUT_ENABLE_BIT];
      end
      if (wr_rtmr) begin
        elapsed_prescaler_reg <= rtmr_new[COUNT_W-1:0];
      end
      if (wr_rtar) begin
        alarm_compare_value_reg <= rtar_new[ELAPSED_W-1:0];
      end
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  logic [COUNT_W-1:0] interval_count, watchdog_count, elapsed_pre_count;
  logic [WATCHDOG_PRESCALE_W-1:0] watchdog_pre_count;
  logic interval_wrap, watchdog_pre_wrap, watchdog_wrap, elapsed_pre_wrap;
  logic watchdog_restart, interval_event, watchdog_overflow, elapsed_tick, alarm_hit;
  logic [ELAPSED_W-1:0] elapsed_plus_one;

  // Counters restart from the value being written, not the old one
  logic [COUNT_W-1:0] interval_load, elapsed_load;
  assign interval_load = wr_pimr ? pimr_new[COUNT_W-1:0] : interval_load_value_reg;
  assign elapsed_load = wr_rtmr ? rtmr_new[COUNT_W-1:0] : elapsed_prescaler_reg;
  assign watchdog_restart = wr_ctrl && wr_cmd[WATCHDOG_RESTART_BIT];

  reload_counter #(.W(COUNT_W), .RESET_COUNT(16'hFFFF)) interval_counter (
    .clk(clk), .rst_n(rst_n), .restart(wr_pimr), .enable(1'b1),
    .load_value(interval_load), .count(interval_count), .wrap(interval_wrap)
  );

  // Divide-by-128 restarts with the watchdog so the first tick is a full one
  reload_counter #(.W(WATCHDOG_PRESCALE_W), .RESET_COUNT(7'h7F)) watchdog_prescaler (
    .clk(clk), .rst_n(rst_n), .restart(watchdog_restart), .enable(1'b1),
    .load_value(7'h00), .count(watchdog_pre_count), .wrap(watchdog_pre_wrap)
  );

  reload_counter #(.W(COUNT_W), .RESET_COUNT(16'hFFFF)) watchdog_counter (
    .clk(clk), .rst_n(rst_n), .restart(watchdog_restart), .enable(watchdog_pre_wrap),
    .load_value(watchdog_load_value_reg), .count(watchdog_count), .wrap(watchdog_wrap)
  );

  reload_counter #(.W(COUNT_W), .RESET_COUNT(16'h7FFF)) elapsed_prescaler (
    .clk(clk), .rst_n(rst_n), .restart(wr_rtmr), .enable(1'b1),
    .load_value(elapsed_load), .count(elapsed_pre_count), .wrap(elapsed_pre_wrap)
  );

  // A restart in the same cycle cancels the event it would race
  assign interval_event = interval_wrap && !wr_pimr;
  assign watchdog_overflow = watchdog_wrap && !watchdog_restart;
  assign elapsed_tick = elapsed_pre_wrap && !wr_rtmr;
  assign elapsed_plus_one = ELAPSED_W'(elapsed_count_value_reg + 1'b1);
  // Alarm zero matches on the roll-over, the longest delay
  assign alarm_hit = elapsed_tick && (elapsed_plus_one == alarm_compare_value_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_count_value_reg <= 20'h00000;
    end else if (wr_rtmr) begin
      elapsed_count_value_reg <= 20'h00000;
    end else if (elapsed_tick) begin
      elapsed_count_value_reg <= elapsed_plus_one;
    end
  end

  // ****************************************
  // Status, mask and interrupt
  // ****************************************
  logic [N_FLAGS-1:0] flag_set;
  assign flag_set[FLAG_INTERVAL] = interval_event;
  assign flag_set[FLAG_WATCHDOG] = watchdog_overflow;
  assign flag_set[FLAG_INCREMENT] = elapsed_tick;
  assign flag_set[FLAG_ALARM] = alarm_hit;
  // Set wins over the read clear so no event is lost
  assign timer_status_next = (rd_status ? 4'h0 : timer_status_reg) | flag_set;
  assign interrupt_mask_next = (interrupt_mask_reg | (wr_ier ? wr_cmd[N_FLAGS-1:0] : 4'h0)) &
                               ~(wr_idr ? wr_cmd[N_FLAGS-1:0] : 4'h0);
  assign pulse_count_next = (watchdog_overflow && overflow_output_enable_reg) ? 4'(OVERFLOW_PULSE_CYCLES) :
                            (pulse_count_reg != 4'h0) ? 4'(pulse_count_reg - 1'b1) : 4'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_status_reg <= 4'h0;
      interrupt_mask_reg <= 4'h0;
      pulse_count_reg <= 4'h0;
      irq_reg <= 1'b0;
      watchdog_reset_reg <= 1'b0;
      overflow_output_n_reg <= 1'b1;
    end else begin
      timer_status_reg <= timer_status_next;
      interrupt_mask_reg <= interrupt_mask_next;
      pulse_count_reg <= pulse_count_next;
      irq_reg <= |(timer_status_next & interrupt_mask_next);
      watchdog_reset_reg <= watchdog_overflow && overflow_reset_enable_reg;
      overflow_output_n_reg <= (pulse_count_next == 4'h0);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign timer_irq = irq_reg;
  assign watchdog_reset = watchdog_reset_reg;
  assign overflow_output_n = overflow_output_n_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_restart_reload: assert property (watchdog_restart |=>
    watchdog_count == 16'($past(watchdog_load_value_reg) - 16'h0001) && watchdog_pre_count == 7'h7F)
    else $error("watchdog restart did not reload");
  chk_mode_no_restart: assert property (wr_wdmr |=>
    watchdog_pre_count == 7'($past(watchdog_pre_count) - 7'h01) &&
    ($past(watchdog_pre_wrap) || watchdog_count == $past(watchdog_count)))
    else $error("watchdog mode write restarted the watchdog");
  chk_interval_reload: assert property (interval_event |=>
    interval_count == 16'($past(interval_load_value_reg) - 16'h0001))
    else $error("interval counter did not reload");
  chk_pimr_restart: assert property (wr_pimr |=>
    interval_count == 16'($past(pimr_new[15:0]) - 16'h0001) && interval_load_value_reg == $past(pimr_new[15:0]))
    else $error("interval write did not restart counter");
  chk_reset_gate: assert property (watchdog_overflow |=>
    watchdog_reset_reg == $past(overflow_reset_enable_reg))
    else $error("internal reset not gated by enable");
  chk_pulse_low_eight: assert property (watchdog_overflow && overflow_output_enable_reg |=>
    !overflow_output_n_reg [*8] ##1 overflow_output_n_reg)
    else $error("overflow output pulse not eight cycles");
  chk_pulse_quiet: assert property (watchdog_overflow && !overflow_output_enable_reg && overflow_output_n_reg |=>
    overflow_output_n_reg)
    else $error("overflow output moved while disabled");
  chk_interval_flag: assert property (interval_event |=> timer_status_reg[FLAG_INTERVAL])
    else $error("interval flag not set");
  chk_status_clear: assert property (rd_status && !watchdog_overflow |=> !timer_status_reg[FLAG_WATCHDOG])
    else $error("status read did not clear watchdog flag");
  chk_mask_enable: assert property (wr_ier && !wr_idr |=>
    (interrupt_mask_reg & $past(wr_cmd[3:0])) == $past(wr_cmd[3:0]))
    else $error("enable write did not set mask");
  chk_mask_disable: assert property (wr_idr |=> (interrupt_mask_reg & $past(wr_cmd[3:0])) == 4'h0)
    else $error("disable write did not clear mask");
  chk_elapsed_clear: assert property (wr_rtmr |=> elapsed_count_value_reg == 20'h00000)
    else $error("elapsed mode write did not clear count");
  chk_alarm_flag: assert property (alarm_hit |=>
    timer_status_reg[FLAG_ALARM] && elapsed_count_value_reg == $past(alarm_compare_value_reg))
    else $error("alarm match not flagged");
  chk_irq_follows: assert property ((timer_status_reg & interrupt_mask_reg) == 4'h0 |-> !irq_reg)
    else $error("interrupt high with no enabled flag");

  cov_interval_event: cover property (interval_event);
  cov_overflow_pulse: cover property (watchdog_overflow && overflow_output_enable_reg);
  cov_alarm_hit: cover property (alarm_hit);
  cov_status_read_race: cover property (rd_status && |flag_set);

endmodule : slow_clock_system_timer

`default_nettype wire

/* bench/tb_slow_clock_system_timer.sv */
/*
  Self-checking bench for the slow clock system timer: AXI4-Lite register
  access, interval, elapsed-time, alarm and watchdog behaviour.
  Assumes the timer package and design files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_slow_clock_system_timer
  import slow_timer_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [1:0] r;
  logic awready, wready, bvalid, arready, rvalid, irq, wd_rst, ovf_n;
  logic [31:0] low_cnt = '0;
  logic [31:0] pulses = '0;
  int bad_count = 0;
  int total_checks = 0;

  always #25 clk = ~clk;

  slow_clock_system_timer i_dut (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .timer_irq(irq), .watchdog_reset(wd_rst), .overflow_output_n(ovf_n)
  );

  // ****************************************
  // Overflow output and reset pulse monitor
  // ****************************************
  always @(negedge clk) begin
    if (ovf_n === 1'b0) low_cnt++;
    if (wd_rst === 1'b1) pulses++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Ready and valid seen at the falling edge hold through the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
    logic ta, tw, tb;
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end while (!tb && n < 100);
    chk({29'h0, tb, r}, {29'h0, 1'b1, er});
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
                    input logic [1:0] er = RESP_OKAY);
    logic ta, tb;
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      n++;
    end while (!tb && n < 100);
    chk({29'h0, tb, r}, {29'h0, 1'b1, er});
    chk(d & m, e);
  endtask : rc

  task automatic irq_is(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask : irq_is

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(OFF_PERIODIC_INTERVAL_MODE, PERIODIC_INTERVAL_MODE_RST);
    rc(OFF_WATCHDOG_MODE, WATCHDOG_MODE_RST);
    rc(OFF_ELAPSED_TIME_MODE, ELAPSED_TIME_MODE_RST);
    rc(OFF_ELAPSED_TIME_ALARM, ELAPSED_TIME_ALARM_RST);
    rc(OFF_INTERRUPT_MASK, 32'h0);
    rc(OFF_TIMER_STATUS, 32'h0);
    rc(OFF_ELAPSED_TIME_CURRENT, 32'h0);
    rc(OFF_TIMER_CONTROL, 32'h0);
    rc(8'h28, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h28, 32'h1, RESP_SLVERR);
    wr(OFF_INTERRUPT_ENABLE, 32'h0000000B);
    rc(OFF_INTERRUPT_MASK, 32'h0000000B);
    wr(OFF_INTERRUPT_DISABLE, 32'h0000000A);
    rc(OFF_INTERRUPT_MASK, 32'h00000001);
    // Rewrite before expiry must push the event out
    wr(OFF_PERIODIC_INTERVAL_MODE, 32'h28);
    tick(25);
    wr(OFF_PERIODIC_INTERVAL_MODE, 32'h28);
    tick(25);
    rc(OFF_TIMER_STATUS, 32'h0);
    irq_is(1'b0);
    tick(20);
    irq_is(1'b1);
    rc(OFF_TIMER_STATUS, 32'h1);
    rc(OFF_TIMER_STATUS, 32'h0);
    irq_is(1'b0);
    tick(25);
    rc(OFF_TIMER_STATUS, 32'h1);
    rc(OFF_PERIODIC_INTERVAL_MODE, 32'h28);
    wr(OFF_PERIODIC_INTERVAL_MODE, 32'h0);
    wr(OFF_ELAPSED_TIME_ALARM, 32'h3);
    wr(OFF_ELAPSED_TIME_MODE, 32'h8);
    rc(OFF_ELAPSED_TIME_CURRENT, 32'h0);
    tick(40);
    irq_is(1'b0);
    rc(OFF_TIMER_STATUS, 32'hC);
    rc(OFF_ELAPSED_TIME_CURRENT, 32'h4, 32'hFFFFFFFC);
    rc(OFF_ELAPSED_TIME_ALARM, 32'h3);
    // Watchdog: load 2 gives 256 cycles to overflow
    wr(OFF_WATCHDOG_MODE, 32'h00030002);
    wr(OFF_TIMER_CONTROL, 32'h1);
    tick(240);
    chk(low_cnt + pulses, 32'h0);
    // A zero restart bit must not push the overflow out
    wr(OFF_TIMER_CONTROL, 32'h0);
    tick(40);
    chk(low_cnt, 32'h8);
    chk(pulses, 32'h1);
    rc(OFF_TIMER_STATUS, 32'h2, 32'h2);
    wr(OFF_WATCHDOG_MODE, 32'h00000002);
    // Flag due before a wrongly restarted counter could overflow
    tick(230);
    chk(low_cnt, 32'h8);
    chk(pulses, 32'h1);
    rc(OFF_TIMER_STATUS, 32'h2, 32'h2);
    finish_test();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    finish_test();
  end

endmodule : tb_slow_clock_system_timer

`default_nettype wire
